// [twowire_clk_pkg.sv]
// Purpose : shared constants for the two-wire transfer clock select block
// Assumes : 20 MHz main clock, 32-bit AXI4-Lite register bus
// Notes   : all offsets are byte addresses of aligned words
package twowire_clk_pkg;

  // ********************************************************************
  // bus and register map
  // ********************************************************************
  localparam int          ADDR_W        = 28;            // bus address width
  localparam int          NUM_CHAN      = 3;             // two-wire channels
  localparam logic [27:0] OFS_CLK_SEL0  = 28'hfff_fd84;  // channel 0 clock select
  localparam logic [27:0] OFS_CLK_SEL1  = 28'hfff_fd94;  // channel 1 clock select
  localparam logic [27:0] OFS_CLK_SEL2  = 28'hfff_fda4;  // channel 2 clock select
  localparam logic [27:0] OFS_OP_ENABLE = 28'hfff_fe00;  // operation enable bits
  localparam logic [27:0] OFS_EXPAND0   = 28'hfff_fe04;  // function expansion ch 0
  localparam logic [27:0] OFS_EXPAND1   = 28'hfff_fe08;  // function expansion ch 1
  localparam logic [27:0] OFS_EXPAND2   = 28'hfff_fe0c;  // function expansion ch 2
  localparam logic [27:0] OFS_PRESC0    = 28'hfff_fe10;  // prescaler for ch 0
  localparam logic [27:0] OFS_PRESC1    = 28'hfff_fe14;  // prescaler for ch 1 and 2

  // ********************************************************************
  // field layout and reset values
  // ********************************************************************
  localparam int          CLK_LEVEL_BIT = 5;             // clock line level, read only
  localparam int          DATA_LEVEL_BIT= 4;             // data line level, read only
  localparam int          SPEED_BIT     = 3;             // 1 = high-speed mode
  localparam int          FILTER_BIT    = 2;             // noise filter enable
  localparam int          DIV_HI_BIT    = 1;             // divider code high
  localparam int          DIV_LO_BIT    = 0;             // divider code low
  localparam int          XFAST_BIT     = 0;             // extra-fast bit
  localparam logic [7:0]  CLK_SEL_WMASK = 8'h0f;         // writable clock select bits
  localparam logic [7:0]  REG_RESET     = 8'h00;         // reset value of all registers
  localparam logic [1:0]  RESP_OKAY     = 2'h0;          // axi okay
  localparam logic [1:0]  RESP_DECERR   = 2'h3;          // axi decode error

  // ********************************************************************
  // prescaler codes and clock period bases
  // ********************************************************************
  localparam logic [7:0]  PRESC_DIV1    = 8'h18;         // fxx through
  localparam logic [7:0]  PRESC_DIV2    = 8'h10;         // fxx / 2
  localparam logic [7:0]  PRESC_DIV3    = 8'h11;         // fxx / 3
  localparam logic [7:0]  PRESC_DIV4    = 8'h12;         // fxx / 4
  localparam logic [7:0]  PRESC_DIV5    = 8'h13;         // fxx / 5
  localparam logic [6:0]  BASE_STD0     = 7'h2c;         // 44 ticks
  localparam logic [6:0]  BASE_STD1     = 7'h56;         // 86 ticks
  localparam logic [6:0]  BASE_STD3     = 7'h42;         // 66 ticks
  localparam logic [6:0]  BASE_HS       = 7'h18;         // 24 ticks
  localparam logic [6:0]  BASE_HS3      = 7'h12;         // 18 ticks
  localparam logic [6:0]  BASE_XFAST    = 7'h0c;         // 12 ticks
  localparam logic [1:0]  FILT_LEN      = 2'h2;          // extra stable cycles when filtering
  localparam logic [1:0]  DIV_CODE_FXX  = 2'h2;          // code that fixes selection at fxx
  localparam logic [1:0]  DIV_CODE_3    = 2'h3;          // code three

endpackage : twowire_clk_pkg

// [line_sense_if.sv]
// Purpose : carrier between the clock select block and one pin sampler
// Assumes : both ends on the main clock
// Notes   : one instance per sensed pin
`timescale 1ns/100ps
interface line_sense_if;
  logic filt_en;   // noise filter on
  logic raw_lvl;   // synchronised level, two flops agree
  logic filt_lvl;  // level after the optional filter
  modport owner   (output filt_en, input raw_lvl, input filt_lvl);
  modport sampler (input filt_en, output raw_lvl, output filt_lvl);
endinterface : line_sense_if

// [line_sampler.sv]
// Purpose : three-flop synchroniser and noise filter for one bus pin
// Assumes : pin is asynchronous to the main clock
// Notes   : idle bus reads high after reset
`timescale 1ns/100ps
module line_sampler
  import twowire_clk_pkg::*;
(
  input  wire logic   i_sys_clk,   // main clock fxx
  input  wire logic   i_resetn,    // async reset, active low
  input  wire logic   i_pin,       // raw pin level
  line_sense_if.sampler ls         // towards the owner
);

  logic       s1_r;    // first stage, read only by s2_r
  logic       s2_r;    // second stage
  logic       s3_r;    // third stage
  logic       raw_r;   // accepted level
  logic       filt_r;  // filtered level
  logic [1:0] cnt_r;   // stability count

  // ********************************************************************
  // synchroniser: a change counts once stages two and three agree
  // ********************************************************************
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s1_r  <= 1'b1;
      s2_r  <= 1'b1;
      s3_r  <= 1'b1;
      raw_r <= 1'b1;
    end
    else
    begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        raw_r <= s3_r;
    end
  end

  // ********************************************************************
  // noise filter: level must hold a few more cycles before it passes
  // ********************************************************************
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      filt_r <= 1'b1;
      cnt_r  <= 2'h0;
    end
    else if (!ls.filt_en || raw_r == filt_r)
    begin
      // filter off, or nothing new: follow directly
      filt_r <= ls.filt_en ? filt_r : raw_r;
      cnt_r  <= 2'h0;
    end
    else if (cnt_r == FILT_LEN)
    begin
      // changed level held long enough
      filt_r <= raw_r;
      cnt_r  <= 2'h0;
    end
    else
      cnt_r <= cnt_r + 2'h1;
  end

  assign ls.raw_lvl  = raw_r;
  assign ls.filt_lvl = filt_r;

endmodule : line_sampler

// [twowire_transfer_clock_select.sv]
// Purpose : transfer clock select and line sensing for three two-wire channels
// Assumes : software programs registers only while operation is disabled
// Notes   : registers reached over AXI4-Lite, 8-bit fields in the low byte
//
// Functional notes
// R1: reset clears every clock select register
// R2: line level bits are read only
// R3: software writes clock select only when disabled
// R4: clock level bit shows clock pin when enabled
// R5: data level bit shows data pin when enabled
// R6: both level bits read zero when disabled
// R7: mode bit picks standard or high speed
// R8: filter bit switches input noise filter on
// R9: high-speed period independent of filter setting
// R10: software writes zeros to bits seven, six
// R11: software writes expansion register only when disabled
// R12: period is m cycles plus rise, fall
// R13: prescaler code picks divided selection clock
// R14: standard, code 00: 44 selection cycles
// R15: standard, code 01: 86 selection cycles
// R16: code 11: 66 standard, 18 high speed
// R17: high speed, code 0x: 24 selection cycles
// R18: extra fast, code 0x: 12 selection cycles
// R19: code 10 uses fxx, ignores prescaler
// R20: software clears prescaler when code fixes fxx
// R21: software avoids unlisted clock setting combinations
// R22: level bits resampled every cycle when enabled
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
module twowire_transfer_clock_select
  import twowire_clk_pkg::*;
(
  input  wire logic                i_sys_clk,      // main clock fxx, 20 MHz
  input  wire logic                i_resetn,       // async reset, active low
  input  wire logic [ADDR_W-1:0]   i_awaddr,       // write address
  input  wire logic                i_awvalid,      // write address valid
  output logic                     o_awready,      // write address ready
  input  wire logic [31:0]         i_wdata,        // write data
  input  wire logic [3:0]          i_wstrb,        // write byte enables
  input  wire logic                i_wvalid,       // write data valid
  output logic                     o_wready,       // write data ready
  output logic [1:0]               o_bresp,        // write response
  output logic                     o_bvalid,       // write response valid
  input  wire logic                i_bready,       // write response ready
  input  wire logic [ADDR_W-1:0]   i_araddr,       // read address
  input  wire logic                i_arvalid,      // read address valid
  output logic                     o_arready,      // read address ready
  output logic [31:0]              o_rdata,        // read data
  output logic [1:0]               o_rresp,        // read response
  output logic                     o_rvalid,       // read data valid
  input  wire logic                i_rready,       // read data ready
  input  wire logic [NUM_CHAN-1:0] i_scl_pin,      // serial clock pin level
  output logic [NUM_CHAN-1:0]      o_scl_out,      // serial clock pin output value
  output logic [NUM_CHAN-1:0]      o_scl_oe,       // serial clock pin pulled low
  input  wire logic [NUM_CHAN-1:0] i_sda_pin,      // serial data pin level
  output logic [NUM_CHAN-1:0]      o_sda_out,      // serial data pin output value
  output logic [NUM_CHAN-1:0]      o_sda_oe        // serial data pin pulled low
);

  // ********************************************************************
  // register storage
  // ********************************************************************
  logic [7:0]          clk_sel_r [NUM_CHAN];  // clock select, writable part
  logic [NUM_CHAN-1:0] xfast_r;               // extra-fast bit per channel
  logic [NUM_CHAN-1:0] op_en_r;               // operation enable per channel
  logic [7:0]          presc_r [2];           // prescaler select registers
  logic [NUM_CHAN-1:0] clk_lvl_r;             // sampled clock line level
  logic [NUM_CHAN-1:0] dat_lvl_r;             // sampled data line level

  // ********************************************************************
  // bus handshake state
  // ********************************************************************
  logic        bvalid_r;  // write response pending
  logic [1:0]  bresp_r;   // write response code
  logic        rvalid_r;  // read data pending
  logic [1:0]  rresp_r;   // read response code
  logic [31:0] rdata_r;   // read data held
  logic        wr_go;     // write address and data taken now
  logic        rd_go;     // read address taken now
  logic        wr_hit;    // write address decodes
  logic [7:0]  rd_val;    // read value of addressed register
  logic        rd_hit;    // read address decodes

  // write address and data are taken together once both are offered and no write response is pending
  assign wr_go     = i_awvalid && i_wvalid && !bvalid_r;
  assign o_awready = wr_go;
  assign o_wready  = wr_go;
  assign rd_go     = i_arvalid && !rvalid_r;
  assign o_arready = !rvalid_r;
  assign o_bvalid  = bvalid_r;
  assign o_bresp   = bresp_r;
  assign o_rvalid  = rvalid_r;
  assign o_rresp   = rresp_r;
  assign o_rdata   = rdata_r;

  // data line is sensed only; no drive from this block
  assign o_sda_out = '0;
  assign o_sda_oe  = '0;
  // open-drain clock: output value always low, enable pulls the line
  assign o_scl_out = '0;

  // ********************************************************************
  // write address decode
  // ********************************************************************
  always_comb
  begin
    unique case (i_awaddr)
      OFS_CLK_SEL0, OFS_CLK_SEL1, OFS_CLK_SEL2,
      OFS_OP_ENABLE, OFS_EXPAND0, OFS_EXPAND1,
      OFS_EXPAND2, OFS_PRESC0, OFS_PRESC1: wr_hit = 1'b1;
      default:                             wr_hit = 1'b0;
    endcase
  end

  // ********************************************************************
  // register writes, low byte lane only
  // ********************************************************************
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      // every register clears, so standard mode, filter off, code 00
      for (int c = 0; c < NUM_CHAN; c++)
        clk_sel_r[c] <= REG_RESET;              // see R1
      presc_r[0] <= REG_RESET;
      presc_r[1] <= REG_RESET;
      xfast_r    <= '0;
      op_en_r    <= '0;
    end
    else if (wr_go && i_wstrb[0])
    begin
      unique case (i_awaddr)
        // level bits and top bits cannot be written
        OFS_CLK_SEL0:  clk_sel_r[0] <= i_wdata[7:0] & CLK_SEL_WMASK; // see R2
        OFS_CLK_SEL1:  clk_sel_r[1] <= i_wdata[7:0] & CLK_SEL_WMASK; // see R2
        OFS_CLK_SEL2:  clk_sel_r[2] <= i_wdata[7:0] & CLK_SEL_WMASK; // see R2
        OFS_OP_ENABLE: op_en_r      <= i_wdata[NUM_CHAN-1:0];
        OFS_EXPAND0:   xfast_r[0]   <= i_wdata[XFAST_BIT];
        OFS_EXPAND1:   xfast_r[1]   <= i_wdata[XFAST_BIT];
        OFS_EXPAND2:   xfast_r[2]   <= i_wdata[XFAST_BIT];
        OFS_PRESC0:    presc_r[0]   <= i_wdata[7:0];
        OFS_PRESC1:    presc_r[1]   <= i_wdata[7:0];
        default:       ;                        // unmapped: nothing stored
      endcase
    end
  end

  // ********************************************************************
  // write response, one cycle after the transfer is taken
  // ********************************************************************
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? RESP_OKAY : RESP_DECERR;
    end
    else if (i_bready)
      bvalid_r <= 1'b0;
  end

  // ********************************************************************
  // read mux, level bits merged into the clock select image
  // ********************************************************************
  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    unique case (i_araddr)
      OFS_CLK_SEL0, OFS_CLK_SEL1, OFS_CLK_SEL2:
      begin
        for (int c = 0; c < NUM_CHAN; c++)
          if (i_araddr == (OFS_CLK_SEL0 + 28'(c) * 28'h000_0010))
          begin
            rd_val                 = clk_sel_r[c];
            rd_val[CLK_LEVEL_BIT]  = clk_lvl_r[c];   // see R4
            rd_val[DATA_LEVEL_BIT] = dat_lvl_r[c];   // see R5
          end
      end
      OFS_OP_ENABLE: rd_val = 8'(op_en_r);
      OFS_EXPAND0:   rd_val = {7'h00, xfast_r[0]};
      OFS_EXPAND1:   rd_val = {7'h00, xfast_r[1]};
      OFS_EXPAND2:   rd_val = {7'h00, xfast_r[2]};
      OFS_PRESC0:    rd_val = presc_r[0];
      OFS_PRESC1:    rd_val = presc_r[1];
      default:       rd_hit = 1'b0;             // unmapped reads zero
    endcase
  end

  // ********************************************************************
  // read data channel, answer one cycle after the address is taken
  // ********************************************************************
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end
    else if (rd_go)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_DECERR;
      rdata_r  <= {24'h00_0000, rd_val};
    end
    else if (i_rready)
      rvalid_r <= 1'b0;
  end

  // ********************************************************************
  // per-channel line sensing and clock generation
  // ********************************************************************
  for (genvar c = 0; c < NUM_CHAN; c++)
  begin : g_chan
    line_sense_if scl_ls ();               // clock pin carrier
    line_sense_if sda_ls ();               // data pin carrier
    logic [7:0] presc;                     // prescaler feeding this channel
    logic [2:0] sel_div;                   // selection clock divisor, 0 = stopped
    logic [6:0] base;                      // selection ticks per period
    logic [2:0] pre_cnt_r;                 // prescaler count
    logic [6:0] per_cnt_r;                 // ticks within the period
    logic       tick;                      // one selection clock tick
    logic       low_half;                  // line held low in this half
    logic       run;                       // clock generator active

    // filter on only by the filter bit
    assign scl_ls.filt_en = clk_sel_r[c][FILTER_BIT];   // see R8
    assign sda_ls.filt_en = clk_sel_r[c][FILTER_BIT];   // see R8

    line_sampler u_scl
    (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_pin     (i_scl_pin[c]),
      .ls        (scl_ls.sampler)
    );

    line_sampler u_sda
    (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_pin     (i_sda_pin[c]),
      .ls        (sda_ls.sampler)
    );

    // level bits follow the pins while enabled, else read zero
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
      if (!i_resetn)
      begin
        clk_lvl_r[c] <= 1'b0;
        dat_lvl_r[c] <= 1'b0;
      end
      else
      begin
        clk_lvl_r[c] <= op_en_r[c] & scl_ls.filt_lvl;   // see R4, R6, R22
        dat_lvl_r[c] <= op_en_r[c] & sda_ls.filt_lvl;   // see R5, R6, R22
      end
    end

    // channel 0 has its own prescaler, others share the second
    assign presc = (c == 0) ? presc_r[0] : presc_r[1];

    // selection clock divisor from prescaler code or fixed fxx
    always_comb
    begin
      if (clk_sel_r[c][DIV_HI_BIT:DIV_LO_BIT] == DIV_CODE_FXX)
        sel_div = 3'h1;                                 // see R19
      else
      begin
        unique case (presc)
          PRESC_DIV1: sel_div = 3'h1;                   // see R13
          PRESC_DIV2: sel_div = 3'h2;                   // see R13
          PRESC_DIV3: sel_div = 3'h3;                   // see R13
          PRESC_DIV4: sel_div = 3'h4;                   // see R13
          PRESC_DIV5: sel_div = 3'h5;                   // see R13
          default:    sel_div = 3'h0;                   // divided clock stopped
        endcase
      end
    end

    // period in selection ticks from mode, divider code, extra fast
    always_comb
    begin
      if (!clk_sel_r[c][SPEED_BIT])
      begin
        // standard mode
        unique case (clk_sel_r[c][DIV_HI_BIT:DIV_LO_BIT])
          2'h0:    base = BASE_STD0;                    // see R7, R14
          2'h3:    base = BASE_STD3;                    // see R16
          default: base = BASE_STD1;                    // see R15, R19
        endcase
      end
      else if (clk_sel_r[c][DIV_HI_BIT:DIV_LO_BIT] == DIV_CODE_3)
        base = BASE_HS3;                                // see R16
      else if (xfast_r[c])
        base = BASE_XFAST;                              // see R18, R19
      else
        base = BASE_HS;                                 // see R7, R17
      // the filter bit takes no part here
    end                                                 // see R9

    assign run      = op_en_r[c] && (sel_div != 3'h0);
    assign tick     = run && (pre_cnt_r == sel_div - 3'h1);
    assign low_half = per_cnt_r < (base >> 1);

    // prescaler: one tick every sel_div main clocks
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
      if (!i_resetn)
        pre_cnt_r <= 3'h0;
      else if (!run || tick)
        pre_cnt_r <= 3'h0;
      else
        pre_cnt_r <= pre_cnt_r + 3'h1;
    end

    // period counter: the wrap waits until the released line is seen high
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
      if (!i_resetn)
        per_cnt_r <= 7'h00;
      else if (!run)
        per_cnt_r <= 7'h00;
      else if (tick && (per_cnt_r != base - 7'h01 || scl_ls.raw_lvl))
      begin
        // a peer holding the line low stretches the last high tick; the
        // half is long enough for the synchroniser to see a free line rise
        if (per_cnt_r == base - 7'h01)
          per_cnt_r <= 7'h00;                           // see R12
        else
          per_cnt_r <= per_cnt_r + 7'h01;               // see R12
      end
    end

    // open-drain drive: pull low during the low half only
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
      if (!i_resetn)
        o_scl_oe[c] <= 1'b0;
      else
        o_scl_oe[c] <= run && low_half;                 // see R12
    end
  end

endmodule : twowire_transfer_clock_select

// [twowire_bus_partner.sv]
// Purpose : far-side devices on the three two-wire channels
// Assumes : open-drain lines with pull-ups
// Notes   : hold inputs let the bench pull a line low
`timescale 1ns/100ps
module twowire_bus_partner (
  input  wire logic [2:0] i_scl_oe,   // design pulls clock low
  input  wire logic [2:0] i_sda_oe,   // design pulls data low
  input  wire logic [2:0] i_hold_scl, // peer stretches clock
  input  wire logic [2:0] i_hold_sda, // peer pulls data low
  output logic      [2:0] o_scl,      // wired clock level
  output logic      [2:0] o_sda       // wired data level
);
  // wired-and: a released line rises to the pull-up
  assign o_scl = ~(i_scl_oe | i_hold_scl);
  assign o_sda = ~(i_sda_oe | i_hold_sda);
endmodule : twowire_bus_partner

// [twowire_transfer_clock_select_properties.sv]
// Purpose : port checks for the transfer clock select block
// Assumes : one clock, async active-low reset
// Notes   : attached by the bind at the foot
`timescale 1ns/100ps
module twowire_clk_sel_checker (
  input wire logic        i_sys_clk,
  input wire logic        i_resetn,
  input wire logic        i_awvalid,
  input wire logic        i_wvalid,
  input wire logic        o_awready,
  input wire logic        o_bvalid,
  input wire logic [1:0]  o_bresp,
  input wire logic        i_bready,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic        i_rready,
  input wire logic [2:0]  o_scl_oe
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  write_ready_a: assert property (o_awready == (i_awvalid && i_wvalid && !o_bvalid))
    else $error("write ready wrong");
  read_ready_a: assert property (o_arready == !o_rvalid)
    else $error("read ready wrong");
  write_answer_a: assert property (o_awready |=> o_bvalid)
    else $error("write response late");
  write_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late");
  read_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  upper_zero_a: assert property (o_rvalid |-> o_rdata[31:6] == 26'h0)
    else $error("upper read bits set");
  reset_idle_a: assert property ($rose(i_resetn) |-> !o_bvalid && o_scl_oe == 3'h0)
    else $error("not idle after reset");
  cover property (o_awready);
  cover property (i_arvalid && o_arready);
  cover property ($rose(o_scl_oe[0]));
endmodule : twowire_clk_sel_checker

bind twowire_transfer_clock_select twowire_clk_sel_checker chk (.*);

// [tb_twowire_transfer_clock_select.sv]
// Purpose : self-checking bench for the transfer clock select block
// Assumes : 20 MHz clock, bench is the AXI4-Lite master
// Notes   : periods are compared with a model built from the table
`timescale 1ns/100ps
module tb_twowire_transfer_clock_select
  import twowire_clk_pkg::*;
;
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
  logic              i_sys_clk = 1'b0, i_resetn = 1'b0, i_awvalid = 1'b0;
  logic              i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [ADDR_W-1:0] i_awaddr = '0, i_araddr = '0;
  logic [31:0]       i_wdata = '0, o_rdata;
  logic [3:0]        i_wstrb = 4'hf;
  logic              o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]        o_bresp, o_rresp;
  logic [2:0]        i_scl_pin, i_sda_pin, o_scl_out, o_scl_oe, o_sda_out, o_sda_oe;
  logic [2:0]        hold_scl = 3'h0, hold_sda = 3'h0; // peer pulls
  logic [7:0]        d;
  int                n_errors = 0, num_checks = 0;
  time               t;
  int                sels [10] = '{0, 1, 2, 3, 8, 8, 12, 11, 8, 10};
  int                xfs [10] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1};
  int                pss [10] = '{24, 16, 0, 17, 18, 24, 24, 16, 19, 0};
  twowire_transfer_clock_select dut (.*);
  twowire_bus_partner peer (.i_scl_oe(o_scl_oe), .i_sda_oe(o_sda_oe), .i_hold_scl(hold_scl),
    .i_hold_sda(hold_sda), .o_scl(i_scl_pin), .o_sda(i_sda_pin));
  initial forever #25 i_sys_clk = ~i_sys_clk;
  // write one register and compare the response code
  task automatic wr(input logic [27:0] a, input logic [7:0] v, input logic [1:0] er);
    @(posedge i_sys_clk);
    i_awaddr <= a;
    i_wdata <= {24'h0, v};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    do @(posedge i_sys_clk); while (!o_awready);
    `CHK(o_wready, 1'b1)
    i_awvalid <= 1'b0;
    i_wvalid <= 1'b0;
    @(posedge i_sys_clk);
    i_bready <= 1'b1;
    do @(posedge i_sys_clk); while (!o_bvalid);
    i_bready <= 1'b0;
    `CHK(o_bresp, er)
  endtask : wr
  // read one register and compare data and response
  task automatic rd(input logic [27:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge i_sys_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    do @(posedge i_sys_clk); while (!o_arready);
    i_arvalid <= 1'b0;
    @(posedge i_sys_clk);
    i_rready <= 1'b1;
    do @(posedge i_sys_clk); while (!o_rvalid);
    i_rready <= 1'b0;
    `CHK(o_rdata, {24'h0, e})
    `CHK(o_rresp, er)
  endtask : rd
  // model: clock period in main clocks from the setting table
  function automatic int period(input int s, input int x, input int p);
    int b;
    int c;
    c = s & 3;
    if (!s[3]) b = (c == 0) ? 44 : (c == 3) ? 66 : 86;
    else b = (c == 3) ? 18 : x ? 12 : 24;
    return b * ((c == 2 || p == 24) ? 1 : p - 14);
  endfunction : period
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (40000) @(posedge i_sys_clk);
    n_errors++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(13));
    repeat (6) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    for (int a = 0; a < 3; a++) rd(28'(OFS_CLK_SEL0 + 16 * a), 8'h00, RESP_OKAY);
    rd(OFS_PRESC0, 8'h00, RESP_OKAY);
    for (int a = 0; a < 3; a++)
    begin
      d = 8'($urandom) & 8'h3f;
      wr(28'(OFS_CLK_SEL0 + 16 * a), d, RESP_OKAY);
      rd(28'(OFS_CLK_SEL0 + 16 * a), d & 8'h0f, RESP_OKAY);
    end
    wr(28'h000_0000, 8'h5a, RESP_DECERR);
    rd(28'h000_0000, 8'h00, RESP_DECERR);
    wr(OFS_CLK_SEL1, 8'h00, RESP_OKAY);
    wr(OFS_OP_ENABLE, 8'h02, RESP_OKAY);
    for (int q = 0; q < 4; q++)
    begin
      hold_sda[1] <= q[0];
      hold_scl[1] <= q[1];
      repeat (12) @(posedge i_sys_clk);
      rd(OFS_CLK_SEL1, {2'h0, ~q[1], ~q[0], 4'h0}, RESP_OKAY);
    end
    hold_sda <= 3'h0;
    hold_scl <= 3'h0;
    wr(OFS_OP_ENABLE, 8'h00, RESP_OKAY);
    rd(OFS_CLK_SEL1, 8'h00, RESP_OKAY);
    foreach (sels[k])
    begin
      wr(OFS_OP_ENABLE, 8'h00, RESP_OKAY);
      wr(OFS_CLK_SEL0, 8'(sels[k]), RESP_OKAY);
      wr(OFS_EXPAND0, 8'(xfs[k]), RESP_OKAY);
      wr(OFS_PRESC0, 8'(pss[k]), RESP_OKAY);
      wr(OFS_OP_ENABLE, 8'h01, RESP_OKAY);
      repeat (2) @(posedge o_scl_oe[0]);
      t = $time;
      @(posedge o_scl_oe[0]);
      `CHK(($time - t) / 50, period(sels[k], xfs[k], pss[k]))
      `CHK({o_scl_out, o_sda_out, o_sda_oe}, 9'h000)
    end
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    rd(OFS_CLK_SEL0, 8'h00, RESP_OKAY);
    print_verdict();
  end
endmodule : tb_twowire_transfer_clock_select
